// *** include/rmc_consts.svh ***
// Constants for the recorder mode controller: codes, field positions and timing counts.
`ifndef RMC_CONSTS_SVH
`define RMC_CONSTS_SVH

// ****************************************************************
// Mode-control command values
// ****************************************************************
`define RMC_MODE_VAL_MEASURE 8'h00
`define RMC_MODE_VAL_SETTING 8'h01

// ****************************************************************
// Event codes and mask bit positions
// ****************************************************************
`define RMC_EVT_STARTUP      4'h0
`define RMC_EVT_OVERFLOW     4'h1
`define RMC_EVT_USER_LO      4'h2
`define RMC_EVT_MASK_RST     16'h0000
`define RMC_LOG_DEPTH        16
`define RMC_LOG_AW           4

// ****************************************************************
// Display codes
// ****************************************************************
`define RMC_DISP_BLANK       5'h1f
`define RMC_DISP_DASH        5'h10
`define RMC_DISP_FLASH       5'h11
`define RMC_DIGIT_MAX        4'h9
`define RMC_TEST_PASSES      3'h5
`define RMC_COLD_STEPS       4'hf

// ****************************************************************
// Timing (100 MHz system clock)
// ****************************************************************
`define RMC_CLK_MHZ          100
`define RMC_STEP_TIME_US     1000
`define RMC_STEP_CYCLES      (`RMC_STEP_TIME_US * `RMC_CLK_MHZ)
`define RMC_FLASH_TIME_US    250000
`define RMC_FLASH_CYCLES     (`RMC_FLASH_TIME_US * `RMC_CLK_MHZ)

`endif

// *** include/rmc_pkg.sv ***
// Types shared by the recorder mode controller files.
package rmc_pkg;

  typedef enum logic [1:0] {
    RMC_ST_STARTUP = 2'b00,
    RMC_ST_MEASURE = 2'b01,
    RMC_ST_SETTING = 2'b10
  } rmc_mode_t;

  typedef enum logic [1:0] {
    RMC_SU_COLD = 2'b00,
    RMC_SU_TEST = 2'b01,
    RMC_SU_DONE = 2'b10
  } rmc_phase_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] value;
  } rmc_cmd_t;

  typedef struct packed {
    logic [4:0] left;
    logic [4:0] right;
    logic       leftRed;
  } rmc_disp_t;

  typedef struct packed {
    logic [3:0]  code;
    logic [31:0] stamp;
  } rmc_entry_t;

endpackage

// *** src/rmc_log_mem.sv ***
// Event log memory of the recorder mode controller, registered read data.
`timescale 1ns/1ps
`include "rmc_consts.svh"

module rmc_log_mem (
  input  wire logic                      clk_sys,
  input  wire logic                      wrEn,
  input  wire logic [`RMC_LOG_AW-1:0]    wrAddr,
  input  wire rmc_pkg::rmc_entry_t       wrData,
  input  wire logic [`RMC_LOG_AW-1:0]    rdAddr,
  output rmc_pkg::rmc_entry_t            rdData
);

  rmc_pkg::rmc_entry_t mem [`RMC_LOG_DEPTH];

  // No reset on the array; contents are only meaningful below the write count.
  always_ff @(posedge clk_sys) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end

endmodule // rmc_log_mem

// *** src/rmc_mode_ctrl.sv ***
// Recorder mode controller: start-up, measuring and setting modes, port choice, event log.
`timescale 1ns/1ps
`include "rmc_consts.svh"

module rmc_mode_ctrl #(
  parameter int unsigned STEP_CYCLES  = `RMC_STEP_CYCLES,
  parameter int unsigned FLASH_CYCLES = `RMC_FLASH_CYCLES
) (
  input  wire logic                   clk_sys,
  input  wire logic                   reset_n,
  input  wire logic                   memValid,
  input  wire logic                   btnStep,
  input  wire logic                   btnReset,
  input  wire logic                   rsDsr,
  input  wire rmc_pkg::rmc_cmd_t      rsCmd,
  input  wire rmc_pkg::rmc_cmd_t      busCmd,
  input  wire logic                   eraseCmd,
  input  wire logic                   eraseBtn,
  input  wire logic                   evtValid,
  input  wire logic [3:0]             evtCode,
  input  wire logic [31:0]            timeStamp,
  input  wire logic                   maskWrite,
  input  wire logic [15:0]            maskData,
  input  wire logic [`RMC_LOG_AW-1:0] logRdAddr,
  output rmc_pkg::rmc_entry_t         logRdData,
  output logic [`RMC_LOG_AW:0]        logCount,
  output rmc_pkg::rmc_mode_t          mode,
  output rmc_pkg::rmc_disp_t          display,
  output logic                        rsSelected,
  output rmc_pkg::rmc_cmd_t           cmdAccepted,
  output logic                        measureEn,
  output logic                        historyClear,
  output logic                        eraseRecordings,
  output logic                        coldStart,
  output logic                        panelScanEn,
  output logic                        panelCommEn
);

  // ****************************************************************
  // State record
  // ****************************************************************
  typedef struct packed {
    rmc_pkg::rmc_mode_t   mode;
    rmc_pkg::rmc_phase_t  phase;
    logic                 cold;
    logic                 startLogged;
    logic [3:0]           coldStep;
    logic [3:0]           digit;
    logic [2:0]           pass;
    logic [31:0]          stepCnt;
    logic [31:0]          flashCnt;
    logic                 flashOn;
    logic                 dsrMeta;
    logic                 dsrSync;
    logic                 memMeta;
    logic                 memSync;
    logic [1:0]           btnMeta;
    logic [1:0]           btnSync;
    logic                 rsSel;
    rmc_pkg::rmc_cmd_t    cmdOut;
    logic                 histClr;
    logic                 erase;
    logic [15:0]          evtMask;
    logic [`RMC_LOG_AW:0] count;
    logic                 ovfPending;
    rmc_pkg::rmc_disp_t   disp;
  } rmc_state_t;

  rmc_state_t state_r;
  rmc_state_t state_nxt;

  logic                logWr;
  rmc_pkg::rmc_entry_t logData;

  // A cycle counter of width 32 covers both timing periods.
  function automatic logic tick(input logic [31:0] cnt, input int unsigned lim);
    return cnt == 32'(lim - 1);
  endfunction

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // Synchronisers feed only their second stage; everything else reads the second stage.
  always_comb begin
    rmc_pkg::rmc_cmd_t sel;
    logic              evtOk;
    state_nxt = state_r;
    sel       = '0;
    evtOk     = 1'b0;
    logWr     = 1'b0;
    logData   = '0;
    state_nxt.dsrMeta = rsDsr;
    state_nxt.dsrSync = state_r.dsrMeta;
    state_nxt.memMeta = memValid;
    state_nxt.memSync = state_r.memMeta;
    state_nxt.btnMeta = {btnStep, btnReset};
    state_nxt.btnSync = state_r.btnMeta;
    state_nxt.cmdOut  = '0;
    state_nxt.histClr = 1'b0;
    state_nxt.erase   = 1'b0;

    // Port choice follows DSR, otherwise the station bus.
    state_nxt.rsSel = state_r.dsrSync;
    sel = state_r.rsSel ? rsCmd : busCmd;

    // Erase may come from either serial port or the panel.
    state_nxt.erase = eraseCmd | eraseBtn;

    // Mask is written in setting mode only, from either port.
    if (maskWrite && state_r.mode == rmc_pkg::RMC_ST_SETTING) begin
      state_nxt.evtMask = maskData;
    end

    unique case (state_r.mode)
      rmc_pkg::RMC_ST_STARTUP: begin
        state_nxt.stepCnt = tick(state_r.stepCnt, STEP_CYCLES) ? 32'h0 : state_r.stepCnt + 32'h1;
        // Both buttons held force the cold path, whatever the memory check said.
        if (state_r.btnSync == 2'b11 && !state_r.cold) begin
          state_nxt.cold     = 1'b1;
          state_nxt.phase    = rmc_pkg::RMC_SU_COLD;
          state_nxt.coldStep = 4'h0;
          state_nxt.digit    = 4'h0;
          state_nxt.pass     = 3'h0;
        end else if (tick(state_r.stepCnt, STEP_CYCLES)) begin
          unique case (state_r.phase)
            rmc_pkg::RMC_SU_COLD: begin
              if (state_r.coldStep == `RMC_COLD_STEPS) begin
                state_nxt.phase = rmc_pkg::RMC_SU_TEST;
              end else begin
                state_nxt.coldStep = state_r.coldStep + 4'h1;
              end
            end
            rmc_pkg::RMC_SU_TEST: begin
              if (state_r.digit == `RMC_DIGIT_MAX) begin
                state_nxt.digit = 4'h0;
                state_nxt.pass  = state_r.pass + 3'h1;
                if (state_r.pass == `RMC_TEST_PASSES - 3'h1) begin
                  state_nxt.phase = rmc_pkg::RMC_SU_DONE;
                end
              end else begin
                state_nxt.digit = state_r.digit + 4'h1;
              end
            end
            rmc_pkg::RMC_SU_DONE: begin
              state_nxt.mode = rmc_pkg::RMC_ST_MEASURE;
            end
            default: state_nxt.phase = rmc_pkg::RMC_SU_DONE;
          endcase
        end
        // Cold or warm is decided once, on the third edge after reset, when memValid has
        // crossed both stages; before that the second stage still holds its reset zero.
        if (!state_r.startLogged && state_r.stepCnt == 32'h2) begin
          if (!state_r.memSync) begin
            state_nxt.cold = 1'b1;
          end else if (!state_nxt.cold) begin
            // Buttons seen on the same edge keep the cold path that they just chose.
            state_nxt.phase = rmc_pkg::RMC_SU_TEST;
          end
          state_nxt.startLogged = 1'b1;
        end
      end
      rmc_pkg::RMC_ST_MEASURE: begin
        if (sel.valid && sel.value == `RMC_MODE_VAL_SETTING) begin
          state_nxt.mode    = rmc_pkg::RMC_ST_SETTING;
          state_nxt.histClr = 1'b1;
        end
      end
      rmc_pkg::RMC_ST_SETTING: begin
        // A lost RS-232 partner ends setting just like the exit command.
        if ((sel.valid && sel.value == `RMC_MODE_VAL_MEASURE) ||
            (state_r.rsSel && !state_r.dsrSync)) begin
          state_nxt.mode = rmc_pkg::RMC_ST_MEASURE;
        end
        state_nxt.flashCnt = tick(state_r.flashCnt, FLASH_CYCLES) ? 32'h0
                                                                   : state_r.flashCnt + 32'h1;
        if (tick(state_r.flashCnt, FLASH_CYCLES)) begin
          state_nxt.flashOn = !state_r.flashOn;
        end
      end
      default: state_nxt.mode = rmc_pkg::RMC_ST_STARTUP;
    endcase

    if (sel.valid) begin
      state_nxt.cmdOut = sel;
    end

    // Event log: forced entries win over masked ones when both arrive.
    evtOk = evtValid && state_r.evtMask[evtCode];
    if (state_r.mode == rmc_pkg::RMC_ST_STARTUP && state_r.stepCnt == 32'h2 &&
        !state_r.startLogged) begin
      logWr   = 1'b1;
      logData = '{code: `RMC_EVT_STARTUP, stamp: timeStamp};
    end else if (state_r.ovfPending) begin
      logWr   = 1'b1;
      logData = '{code: `RMC_EVT_OVERFLOW, stamp: timeStamp};
      state_nxt.ovfPending = 1'b0;
    end else if (evtOk) begin
      logWr   = 1'b1;
      logData = '{code: evtCode, stamp: timeStamp};
    end
    if (logWr) begin
      if (state_r.count == (`RMC_LOG_AW+1)'(`RMC_LOG_DEPTH - 1) && !state_r.ovfPending) begin
        // The last slot is kept for the overflow entry, so a full log always says so.
        state_nxt.ovfPending = 1'b1;
        logWr                = 1'b0;
      end else if (state_r.count != (`RMC_LOG_AW+1)'(`RMC_LOG_DEPTH)) begin
        state_nxt.count = state_r.count + 1'b1;
      end else begin
        logWr = 1'b0;
      end
    end

    // Display image per mode.
    unique case (state_nxt.mode)
      rmc_pkg::RMC_ST_STARTUP: begin
        if (state_nxt.phase == rmc_pkg::RMC_SU_COLD) begin
          state_nxt.disp = '{left: `RMC_DISP_DASH, right: {1'b0, state_nxt.coldStep},
                             leftRed: 1'b1};
        end else begin
          state_nxt.disp = '{left: {1'b0, state_nxt.digit}, right: {1'b0, state_nxt.digit},
                             leftRed: 1'b1};
        end
      end
      rmc_pkg::RMC_ST_SETTING: begin
        state_nxt.disp.left  = state_nxt.flashOn ? `RMC_DISP_FLASH : `RMC_DISP_BLANK;
        state_nxt.disp.right = state_nxt.disp.left;
      end
      default: begin
        state_nxt.disp = '{left: `RMC_DISP_BLANK, right: `RMC_DISP_BLANK, leftRed: 1'b1};
      end
    endcase
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Reset starts in the cold phase; the synced memory check may redirect to the warm test phase.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_r         <= '0;
      state_r.mode    <= rmc_pkg::RMC_ST_STARTUP;
      state_r.phase   <= rmc_pkg::RMC_SU_COLD;
      state_r.evtMask <= `RMC_EVT_MASK_RST;
      state_r.disp    <= '{left: `RMC_DISP_DASH, right: 5'h00, leftRed: 1'b1};
    end else begin
      state_r <= state_nxt;
    end
  end

  rmc_log_mem u_log (
    .clk_sys (clk_sys),
    .wrEn    (logWr),
    .wrAddr  (state_r.count[`RMC_LOG_AW-1:0]),
    .wrData  (logData),
    .rdAddr  (logRdAddr),
    .rdData  (logRdData)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign mode            = state_r.mode;
  assign display         = state_r.disp;
  assign rsSelected      = state_r.rsSel;
  assign cmdAccepted     = state_r.cmdOut;
  assign measureEn       = state_r.mode == rmc_pkg::RMC_ST_MEASURE;
  assign historyClear    = state_r.histClr;
  assign eraseRecordings = state_r.erase;
  assign coldStart       = state_r.cold;
  assign panelScanEn     = state_r.mode == rmc_pkg::RMC_ST_MEASURE;
  assign panelCommEn     = state_r.mode == rmc_pkg::RMC_ST_MEASURE;
  assign logCount        = state_r.count;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  chk_setting_entry: assert property (
    mode == rmc_pkg::RMC_ST_MEASURE && cmdAccepted.valid == 1'b0 &&
    $past(state_r.rsSel) == state_r.rsSel &&
    (state_r.rsSel ? rsCmd : busCmd) == {1'b1, `RMC_MODE_VAL_SETTING}
    |=> mode == rmc_pkg::RMC_ST_SETTING) else $error("Setting command not obeyed.");
  chk_setting_exit: assert property (
    mode == rmc_pkg::RMC_ST_SETTING &&
    (state_r.rsSel ? rsCmd : busCmd) == {1'b1, `RMC_MODE_VAL_MEASURE}
    |=> mode == rmc_pkg::RMC_ST_MEASURE) else $error("Exit command not obeyed.");
  chk_no_measure_set: assert property (
    mode == rmc_pkg::RMC_ST_SETTING |-> !measureEn && !panelScanEn)
    else $error("Measuring in setting.");
  chk_history_clear: assert property (
    $rose(mode == rmc_pkg::RMC_ST_SETTING) |-> historyClear) else $error("History not cleared.");
  chk_port_follow: assert property (
    $rose(rsDsr) ##1 rsDsr ##1 rsDsr |=> rsSelected) else $error("DSR not followed.");
  chk_disconnect: assert property (
    mode == rmc_pkg::RMC_ST_SETTING && rsSelected && !state_r.dsrSync
    |=> mode == rmc_pkg::RMC_ST_MEASURE) else $error("Disconnect ignored.");
  chk_one_mode: assert property (
    mode inside {rmc_pkg::RMC_ST_STARTUP, rmc_pkg::RMC_ST_MEASURE, rmc_pkg::RMC_ST_SETTING})
    else $error("Illegal mode.");
  chk_measure_blank: assert property (
    $rose(mode == rmc_pkg::RMC_ST_MEASURE) |-> display.left == `RMC_DISP_BLANK)
    else $error("Display not blanked.");
  chk_erase_pass: assert property (
    eraseBtn |=> eraseRecordings) else $error("Erase lost.");
  chk_mask_gate: assert property (
    evtValid && !state_r.evtMask[evtCode] && !state_r.ovfPending && mode != rmc_pkg::RMC_ST_STARTUP
    |=> $stable(logCount)) else $error("Masked event logged.");
  chk_cold_dash: assert property (
    mode == rmc_pkg::RMC_ST_STARTUP && state_r.phase == rmc_pkg::RMC_SU_COLD && coldStart
    |-> display.left == `RMC_DISP_DASH && display.leftRed)
    else $error("Cold progress not shown.");

  cov_enter_setting: cover property ($rose(mode == rmc_pkg::RMC_ST_SETTING));
  cov_cold_start:    cover property ($rose(coldStart));
  cov_reach_measure: cover property ($rose(mode == rmc_pkg::RMC_ST_MEASURE));
  cov_rs_port:       cover property ($rose(rsSelected));
  cov_log_overflow:  cover property ($rose(state_r.ovfPending));

endmodule // rmc_mode_ctrl

// *** dv/rmc_host_model.sv ***
// Behavioural PC, modem and station computer that send mode-control commands.
`timescale 1ns/1ps

module rmc_host_model (
  input  wire logic        clk_sys,
  output rmc_pkg::rmc_cmd_t rsCmd,
  output rmc_pkg::rmc_cmd_t busCmd,
  output logic             rsDsr
);
  // Idle values are not zero so a stale value can never pass for a command.
  initial begin
    rsCmd  = 9'h0aa;
    busCmd = 9'h055;
    rsDsr  = 1'b0;
  end

  // One-cycle command pulse; the value is inverted once the pulse is over.
  task automatic sendCmd(input logic onRs, input logic [7:0] val);
    @(negedge clk_sys);
    if (onRs) rsCmd = {1'b1, val};
    else busCmd = {1'b1, val};
    @(negedge clk_sys);
    if (onRs) rsCmd = {1'b0, ~val};
    else busCmd = {1'b0, ~val};
  endtask

  // Attaching or removing the front-port device drives the handshake level.
  task automatic setDsr(input logic lvl);
    @(negedge clk_sys);
    rsDsr = lvl;
  endtask
endmodule // rmc_host_model

// *** dv/recorder_mode_controller_tb.sv ***
// Self-checking testbench of the recorder mode controller.
`timescale 1ns/1ps
`include "rmc_consts.svh"

module recorder_mode_controller_tb;
  logic clk_sys, reset_n, memValid, btnStep, btnReset, eraseCmd, eraseBtn;
  logic evtValid, maskWrite;
  logic [3:0] evtCode;
  logic [31:0] timeStamp;
  logic [15:0] maskData;
  logic [`RMC_LOG_AW-1:0] logRdAddr;
  logic [`RMC_LOG_AW:0] logCount;
  logic rsDsr, rsSelected, measureEn, historyClear, eraseRecordings;
  logic coldStart, panelScanEn, panelCommEn;
  rmc_pkg::rmc_cmd_t rsCmd, busCmd, cmdAccepted;
  rmc_pkg::rmc_entry_t logRdData, ent;
  rmc_pkg::rmc_mode_t mode;
  rmc_pkg::rmc_disp_t display;
  int error_cnt = 0;
  int cmp_count = 0;
  int cycles = 0;
  int n;
  logic [4:0] d0;

  `define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end

  rmc_host_model host_u (.clk_sys(clk_sys), .rsCmd(rsCmd), .busCmd(busCmd), .rsDsr(rsDsr));

  rmc_mode_ctrl #(.STEP_CYCLES(4), .FLASH_CYCLES(4)) dut_u (
    .clk_sys(clk_sys), .reset_n(reset_n), .memValid(memValid), .btnStep(btnStep),
    .btnReset(btnReset), .rsDsr(rsDsr), .rsCmd(rsCmd), .busCmd(busCmd),
    .eraseCmd(eraseCmd), .eraseBtn(eraseBtn), .evtValid(evtValid), .evtCode(evtCode),
    .timeStamp(timeStamp), .maskWrite(maskWrite), .maskData(maskData),
    .logRdAddr(logRdAddr), .logRdData(logRdData), .logCount(logCount), .mode(mode),
    .display(display), .rsSelected(rsSelected), .cmdAccepted(cmdAccepted),
    .measureEn(measureEn), .historyClear(historyClear), .eraseRecordings(eraseRecordings),
    .coldStart(coldStart), .panelScanEn(panelScanEn), .panelCommEn(panelCommEn));

  // ****************************************************************
  // Clock and hang guard
  // ****************************************************************
  // A 10 ns clock; the guard is far above the fewer than a thousand cycles the tests need.
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      results();
    end
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic doReset(input logic memV);
    @(negedge clk_sys);
    reset_n = 1'b0;
    memValid = memV;
    repeat (10) @(negedge clk_sys);
    reset_n = 1'b1;
  endtask

  // Counts cycles until measuring mode, bounded so a stuck start-up ends.
  task automatic waitMeasure(output int cnt);
    cnt = 0;
    while (mode !== rmc_pkg::RMC_ST_MEASURE && cnt < 600) begin
      @(negedge clk_sys);
      cnt++;
    end
  endtask

  task automatic sendEvt(input logic [3:0] code, input logic [31:0] stamp);
    @(negedge clk_sys);
    evtValid = 1'b1;
    evtCode = code;
    timeStamp = stamp;
    @(negedge clk_sys);
    evtValid = 1'b0;
  endtask

  // Mask load pulse; the design takes it in setting mode only.
  task automatic writeMask(input logic [15:0] m);
    @(negedge clk_sys);
    maskWrite = 1'b1;
    maskData = m;
    @(negedge clk_sys);
    maskWrite = 1'b0;
  endtask

  // Registered read: address at one edge, data settled by the next falling edge.
  task automatic readLog(input logic [3:0] addr, output rmc_pkg::rmc_entry_t e);
    @(negedge clk_sys);
    logRdAddr = addr;
    @(negedge clk_sys);
    e = logRdData;
  endtask

  task automatic results();
    $display("Checks %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Warm start: early command refused, 5 x 10 digit steps plus one, then measuring.
  task automatic testWarmStart();
    doReset(1'b1);
    host_u.sendCmd(1'b0, `RMC_MODE_VAL_SETTING);
    `CHK(mode, rmc_pkg::RMC_ST_STARTUP)
    repeat (20) @(negedge clk_sys);
    d0 = display.right;
    repeat (4) @(negedge clk_sys);
    `CHK(display.right, (d0 == 5'h09) ? 5'h00 : d0 + 5'h01)
    waitMeasure(n);
    `CHK(n > 170 && n < 190, 1'b1)
    `CHK(coldStart, 1'b0)
    `CHK(display.left, `RMC_DISP_BLANK)
    `CHK(display.right, `RMC_DISP_BLANK)
    `CHK({measureEn, panelScanEn, panelCommEn}, 3'b111)
    `CHK(logCount, 5'h01)
    readLog(4'h0, ent);
    `CHK(ent.code, `RMC_EVT_STARTUP)
    writeMask(16'h0004);
    sendEvt(4'h2, 32'h0000_0102);
    `CHK(logCount, 5'h01)
    $display("Test warm start done");
  endtask

  // Setting mode by bus command: flashing, suspended, mask load, leave by value 0.
  task automatic testSetting();
    host_u.sendCmd(1'b0, `RMC_MODE_VAL_SETTING);
    `CHK(mode, rmc_pkg::RMC_ST_SETTING)
    `CHK(historyClear, 1'b1)
    `CHK(cmdAccepted, {1'b1, `RMC_MODE_VAL_SETTING})
    `CHK({measureEn, panelScanEn, panelCommEn}, 3'b000)
    d0 = display.right;
    n = 0;
    repeat (12) begin
      @(negedge clk_sys);
      if (display.right !== d0) n++;
    end
    `CHK(n > 0, 1'b1)
    `CHK(historyClear, 1'b0)
    writeMask(16'h0004);
    host_u.sendCmd(1'b0, `RMC_MODE_VAL_MEASURE);
    `CHK(mode, rmc_pkg::RMC_ST_MEASURE)
    `CHK(measureEn, 1'b1)
    sendEvt(4'h3, 32'h0000_0103);
    sendEvt(4'h2, 32'h1234_abcd);
    `CHK(logCount, 5'h02)
    readLog(4'h1, ent);
    `CHK(ent, {4'h2, 32'h1234_abcd})
    $display("Test setting mode done");
  endtask

  // Front port takes over on handshake, bus ignored, disconnect returns to measuring.
  task automatic testPorts();
    host_u.setDsr(1'b1);
    n = 0;
    while (rsSelected !== 1'b1 && n < 8) begin
      @(negedge clk_sys);
      n++;
    end
    `CHK(rsSelected, 1'b1)
    host_u.sendCmd(1'b0, `RMC_MODE_VAL_SETTING);
    `CHK(mode, rmc_pkg::RMC_ST_MEASURE)
    `CHK(cmdAccepted.valid, 1'b0)
    host_u.sendCmd(1'b1, `RMC_MODE_VAL_SETTING);
    `CHK(mode, rmc_pkg::RMC_ST_SETTING)
    host_u.setDsr(1'b0);
    repeat (6) @(negedge clk_sys);
    `CHK(mode, rmc_pkg::RMC_ST_MEASURE)
    `CHK(rsSelected, 1'b0)
    host_u.sendCmd(1'b1, `RMC_MODE_VAL_SETTING);
    `CHK(mode, rmc_pkg::RMC_ST_MEASURE)
    host_u.sendCmd(1'b0, `RMC_MODE_VAL_SETTING);
    `CHK(mode, rmc_pkg::RMC_ST_SETTING)
    host_u.sendCmd(1'b0, `RMC_MODE_VAL_MEASURE);
    $display("Test port selection done");
  endtask

  // Erase by serial command and by buttons, each a pulse one cycle later.
  task automatic testErase();
    @(negedge clk_sys);
    eraseCmd = 1'b1;
    @(negedge clk_sys);
    eraseCmd = 1'b0;
    `CHK(eraseRecordings, 1'b1)
    eraseBtn = 1'b1;
    @(negedge clk_sys);
    eraseBtn = 1'b0;
    `CHK(eraseRecordings, 1'b1)
    @(negedge clk_sys);
    `CHK(eraseRecordings, 1'b0)
    $display("Test erase done");
  endtask

  // Fill the log past its depth: count saturates and the last slot holds overflow.
  task automatic testOverflow();
    repeat (20) sendEvt(4'h2, 32'h0000_0200);
    `CHK(logCount, 5'h10)
    readLog(4'hf, ent);
    `CHK(ent.code, `RMC_EVT_OVERFLOW)
    $display("Test overflow done");
  endtask

  // Lost memory: dash and running progress, 16 extra steps, old log gone.
  task automatic testColdStart();
    doReset(1'b0);
    repeat (8) @(negedge clk_sys);
    `CHK(display.left, `RMC_DISP_DASH)
    `CHK(display.leftRed, 1'b1)
    d0 = display.right;
    repeat (8) @(negedge clk_sys);
    `CHK(display.right, d0 + 5'h02)
    waitMeasure(n);
    `CHK(n > 234 && n < 254, 1'b1)
    `CHK(coldStart, 1'b1)
    `CHK(logCount, 5'h01)
    $display("Test cold start done");
  endtask

  // Both buttons held during a warm start-up force a cold one.
  task automatic testButtonsCold();
    doReset(1'b1);
    btnStep = 1'b1;
    btnReset = 1'b1;
    repeat (12) @(negedge clk_sys);
    btnStep = 1'b0;
    btnReset = 1'b0;
    waitMeasure(n);
    `CHK(mode, rmc_pkg::RMC_ST_MEASURE)
    `CHK(coldStart, 1'b1)
    $display("Test button cold start done");
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    reset_n = 1'b0;
    memValid = 1'b1;
    btnStep = 1'b0;
    btnReset = 1'b0;
    eraseCmd = 1'b0;
    eraseBtn = 1'b0;
    evtValid = 1'b0;
    evtCode = 4'h0;
    timeStamp = 32'h0;
    maskWrite = 1'b0;
    maskData = 16'h0;
    logRdAddr = 4'h0;
    testWarmStart();
    testSetting();
    testPorts();
    testErase();
    testOverflow();
    testColdStart();
    testButtonsCold();
    results();
  end
endmodule // recorder_mode_controller_tb
